// file: bench/ssc_clock_select_properties.sv
// Purpose: port checks of the clock select block
// Assumes: one clock domain, async active-high reset
// Notes: bound onto every instance of the block
`timescale 1ns/1ps
module ssc_clock_select_properties #(
  parameter logic [3:0] READY_TICKS = 4'hF
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_rd,
  input wire logic i_ext_osc_tick,
  input wire logic i_pll_tick,
  input wire logic i_xtal_amp_ok,
  input wire logic i_pll_locked,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_int_osc_on,
  input wire logic [2:0] o_ext_osc_mode,
  input wire logic o_ext_osc_tick,
  input wire logic o_sysclk,
  input wire logic [1:0] o_sysclk_source,
  input wire logic o_int_osc_ready_flag,
  input wire logic o_crystal_valid_flag,
  input wire logic o_pll_lock_flag
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ==========================================
  // sequences
  sequence ext_rd_s;
    i_sfr_rd && i_sfr_addr == ssc_pkg::ADDR_EXT_CTRL;
  endsequence
  sequence pll_run_s;
    o_sysclk_source == ssc_pkg::SRC_PLL && $stable(o_sysclk_source) && i_pll_tick;
  endsequence
  // ==========================================
  // assertions
  reset_default_a: assert property ($past(i_reset) |-> o_sysclk_source == ssc_pkg::SRC_INT && o_int_osc_on)
    else $error("source or enable wrong after reset");
  ready_off_a: assert property (!o_int_osc_on |-> !o_int_osc_ready_flag)
    else $error("ready set while oscillator off");
  reserved_src_a: assert property (o_sysclk_source != ssc_pkg::SRC_RESERVED)
    else $error("reserved source active");
  switch_low_a: assert property ($changed(o_sysclk_source) |-> !$past(o_sysclk))
    else $error("source switched while sysclk high");
  pll_toggle_a: assert property (pll_run_s |=> o_sysclk_source != ssc_pkg::SRC_PLL || o_sysclk != $past(o_sysclk))
    else $error("pll tick did not toggle sysclk");
  xtal_flag_a: assert property (o_crystal_valid_flag == ($past(o_ext_osc_mode[2:1]) == 2'h3 && $past(i_xtal_amp_ok)))
    else $error("crystal valid flag wrong");
  pll_flag_a: assert property (o_pll_lock_flag == $past(i_pll_locked))
    else $error("pll lock flag wrong");
  // two register stages between the mode and the timer tick
  ext_off_a: assert property (o_ext_osc_mode[2:1] == ssc_pkg::EXT_OFF |-> ##2 !o_ext_osc_tick)
    else $error("tick while external circuit off");
  ext_pass_a: assert property (o_ext_osc_mode == 3'h2 && $stable(o_ext_osc_mode) && i_ext_osc_tick |-> ##2 o_ext_osc_tick)
    else $error("cmos tick not passed");
  ext_bit3_a: assert property (ext_rd_s |=> !o_sfr_rdata[3])
    else $error("reserved bit reads one");
endmodule

bind ssc_clock_select ssc_clock_select_properties #(.READY_TICKS(READY_TICKS)) i_ssc_clock_select_properties (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd),
  .i_ext_osc_tick(i_ext_osc_tick), .i_pll_tick(i_pll_tick), .i_xtal_amp_ok(i_xtal_amp_ok),
  .i_pll_locked(i_pll_locked), .o_sfr_rdata(o_sfr_rdata), .o_int_osc_on(o_int_osc_on),
  .o_ext_osc_mode(o_ext_osc_mode), .o_ext_osc_tick(o_ext_osc_tick), .o_sysclk(o_sysclk),
  .o_sysclk_source(o_sysclk_source), .o_int_osc_ready_flag(o_int_osc_ready_flag),
  .o_crystal_valid_flag(o_crystal_valid_flag), .o_pll_lock_flag(o_pll_lock_flag)
);

// file: bench/ssc_clock_select_test.sv
// Purpose: self-checking bench of the clock select block
// Assumes: ready count shortened to 2 ticks
// Notes: periods measured in i_mclk cycles
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module ssc_clock_select_test;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, trim, rdata, a, d;
  logic wr = 1'b0, rd = 1'b0, pll_en = 1'b0;
  logic int_tick, ext_tick, pll_tick, amp_ok, locked;
  logic int_on, ext_tick_o, sysclk, clk_out, rdy, xv, pll_flag;
  logic [2:0] mode;
  logic [1:0] src;
  logic [7:0] trim_o;
  logic [2:0] range_o;
  logic stick;
  logic [7:0] addrs [5] = '{ssc_pkg::ADDR_INT_TRIM, ssc_pkg::ADDR_EXT_CTRL, ssc_pkg::ADDR_SRC_SEL,
                            ssc_pkg::ADDR_INT_CTRL, 8'h00};
  int fail_count = 0, check_count = 0, cyc = 0, p, n, m, seed = 32'h073f;
  initial trim = $random(seed);
  always #5 i_mclk = ~i_mclk;

  ssc_clock_select #(.READY_TICKS(4'h2)) i_ssc_clock_select (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_factory_trim(trim), .i_int_osc_tick(int_tick),
    .i_ext_osc_tick(ext_tick), .i_pll_tick(pll_tick), .i_xtal_amp_ok(amp_ok), .i_pll_locked(locked),
    .o_int_osc_on(int_on), .o_int_osc_trim(trim_o), .o_ext_osc_mode(mode), .o_ext_osc_range(range_o),
    .o_ext_osc_tick(ext_tick_o), .o_sysclk(sysclk), .o_sysclk_tick(stick), .o_sysclk_source(src),
    .o_clock_out(clk_out), .o_int_osc_ready_flag(rdy), .o_crystal_valid_flag(xv), .o_pll_lock_flag(pll_flag)
  );
  ssc_osc_model i_ssc_osc_model (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_int_on(int_on), .i_mode(mode), .i_pll_en(pll_en),
    .o_int_tick(int_tick), .o_ext_tick(ext_tick), .o_pll_tick(pll_tick), .o_amp_ok(amp_ok), .o_locked(locked)
  );

  // ==========================================
  // helpers
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
    tick(1);
    addr = ad;
    wdata = dt;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    tick(1);
    addr = ad;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic per(input bit w, output int pr);
    int t, r, t0;
    logic v, pv;
    t = 0;
    r = 0;
    t0 = 0;
    pr = 0;
    pv = 1'b1;
    while (r < 3 && t < 500) begin
      tick(1);
      t++;
      v = w ? clk_out : sysclk;
      if (v === 1'b1 && pv === 1'b0) begin
        r++;
        if (r == 2) t0 = t;
        if (r == 3) pr = t - t0;
      end
      pv = v;
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] dt);
    case (ad)
      ssc_pkg::ADDR_INT_TRIM: return dt;
      ssc_pkg::ADDR_EXT_CTRL: return dt & 8'h77;
      ssc_pkg::ADDR_SRC_SEL: return dt & 8'h33;
      ssc_pkg::ADDR_INT_CTRL: return dt & 8'h83;
      default: return 8'h00;
    endcase
  endfunction

  // ==========================================
  // scenarios
  initial begin
    tick(20);
    i_reset = 1'b0;
    tick(20);
    rd_chk(ssc_pkg::ADDR_INT_CTRL, 8'hC0);
    rd_chk(ssc_pkg::ADDR_INT_TRIM, trim);
    `CHK(trim_o, trim)
    rd_chk(ssc_pkg::ADDR_EXT_CTRL, 8'h00);
    rd_chk(ssc_pkg::ADDR_SRC_SEL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr_reg(ssc_pkg::ADDR_INT_CTRL, 8'h80 | c);
      per(0, p);
      `CHK(p, 4 * (8 >> c))
    end
    for (int c = 0; c < 4; c++) begin
      wr_reg(ssc_pkg::ADDR_SRC_SEL, c << 4);
      per(1, p);
      `CHK(p, 4 << c)
    end
    wr_reg(ssc_pkg::ADDR_EXT_CTRL, 8'h6F);
    rd_chk(ssc_pkg::ADDR_EXT_CTRL, 8'h67);
    `CHK(range_o, 3'h7)
    tick(120);
    rd_chk(ssc_pkg::ADDR_EXT_CTRL, 8'hE7);
    wr_reg(ssc_pkg::ADDR_EXT_CTRL, 8'h27);
    rd_chk(ssc_pkg::ADDR_EXT_CTRL, 8'h27);
    wr_reg(ssc_pkg::ADDR_SRC_SEL, 8'h01);
    per(0, p);
    `CHK(p, 6)
    // rc mode halves the external tick rate
    wr_reg(ssc_pkg::ADDR_EXT_CTRL, 8'h57);
    per(0, p);
    `CHK(p, 12)
    wr_reg(ssc_pkg::ADDR_EXT_CTRL, 8'h27);
    wr_reg(ssc_pkg::ADDR_SRC_SEL, 8'h03);
    tick(10);
    `CHK(src, 2'h1)
    `CHK(pll_flag, 1'b0)
    pll_en = 1'b1;
    tick(60);
    `CHK(pll_flag, 1'b1)
    wr_reg(ssc_pkg::ADDR_SRC_SEL, 8'h02);
    per(0, p);
    `CHK(p, 2)
    n = 0;
    m = 0;
    repeat (30) begin
      tick(1);
      if (ext_tick_o === 1'b1) n++;
      if (stick === 1'b1) m++;
    end
    `CHK(n, 10)
    `CHK(m, 15)
    wr_reg(ssc_pkg::ADDR_SRC_SEL, 8'h00);
    wr_reg(ssc_pkg::ADDR_INT_CTRL, 8'h03);
    tick(5);
    `CHK(int_on, 1'b0)
    `CHK(rdy, 1'b0)
    wr_reg(ssc_pkg::ADDR_INT_CTRL, 8'h83);
    per(0, p);
    `CHK(p, 4)
    `CHK(rdy, 1'b1)
    repeat (40) begin
      a = addrs[$unsigned($random(seed)) % 5];
      d = $random(seed);
      if (a == ssc_pkg::ADDR_EXT_CTRL) d = d & 8'hB7;
      wr_reg(a, d);
      rd_chk(a, exp_rd(a, d));
    end
    // second reset in mid-run restores the defaults
    i_reset = 1'b1;
    tick(3);
    i_reset = 1'b0;
    tick(2);
    `CHK(src, ssc_pkg::SRC_INT)
    `CHK(int_on, 1'b1)
    rd_chk(ssc_pkg::ADDR_INT_TRIM, trim);
    summarize();
  end
endmodule

// file: bench/ssc_osc_model.sv
// Purpose: behavioural oscillator sources for the clock select block
// Assumes: ticks synchronous to i_mclk
// Notes: int tick every 2 cycles, ext every 3, pll every cycle
`timescale 1ns/1ps
module ssc_osc_model #(
  parameter int AMP_WAIT = 100,
  parameter int LOCK_WAIT = 50
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_int_on,
  input wire logic [2:0] i_mode,
  input wire logic i_pll_en,
  output logic o_int_tick,
  output logic o_ext_tick,
  output logic o_pll_tick,
  output logic o_amp_ok,
  output logic o_locked
);
  int cnt_q, amp_q, lock_q;
  // ==========================================
  // settle counters
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= 0;
      amp_q <= 0;
      lock_q <= 0;
    end else begin
      cnt_q <= (cnt_q + 1) % 6;
      amp_q <= (i_mode[2:1] == 2'h3) ? amp_q + 1 : 0;
      lock_q <= i_pll_en ? lock_q + 1 : 0;
    end
  end
  assign o_int_tick = i_int_on && (cnt_q % 2 == 1);
  assign o_ext_tick = (i_mode[2:1] != 2'h0) && (cnt_q % 3 == 0);
  assign o_pll_tick = i_pll_en;
  assign o_amp_ok = amp_q >= AMP_WAIT;
  assign o_locked = lock_q >= LOCK_WAIT;
endmodule

// file: pkg/ssc_pkg.sv
// Purpose: shared constants of the system clock source select block
// Assumes: 8-bit register port, ticks sampled on i_mclk
// Notes: register addresses, fields, resets, codes and counts
package ssc_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_INT_TRIM = 8'h8B;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h8C;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h97;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h8A;

  // ==========================================================
  // reset values
  localparam logic [7:0] INT_CTRL_RESET = 8'hC0;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  localparam logic [7:0] SRC_SEL_RESET = 8'h00;
  localparam logic [7:0] TRIM_PRELOAD = 8'h00;

  // ==========================================================
  // field positions
  localparam int INT_ON_BIT = 7;
  localparam int INT_READY_BIT = 6;
  localparam int INT_DIV_LSB = 0;
  localparam int XTAL_VALID_BIT = 7;
  localparam int EXT_MODE_LSB = 4;
  localparam int EXT_RANGE_LSB = 0;
  localparam int CLKOUT_DIV_LSB = 4;
  localparam int SRC_LSB = 0;

  // ==========================================================
  // source codes
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;

  // external mode, upper two bits
  localparam logic [1:0] EXT_OFF = 2'h0;
  localparam logic [1:0] EXT_RC = 2'h2;
  localparam logic [1:0] EXT_CRYSTAL = 2'h3;

  // ==========================================================
  // timing: internal oscillator ticks before ready
  localparam logic [3:0] INT_READY_TICKS = 4'hF;

endpackage

// file: pkg/ssc_tick_if.sv
// Purpose: tick path between the top and its tick conditioners
// Assumes: all signals synchronous to i_mclk
// Notes: shift is log2 of the divide ratio
`timescale 1ns/1ps
interface ssc_tick_if;
  logic tick_in;
  logic [1:0] shift;
  logic [2:0] mode;
  logic stat_in;
  logic tick_out;
  logic stat_out;

  modport div (input tick_in, input shift, output tick_out);
  modport ext (input tick_in, input mode, input stat_in, output tick_out, output stat_out);
endinterface

// file: rtl/ssc_clock_select.sv
// Purpose: system clock source select and oscillator control registers
// Assumes: oscillator and pll edges arrive as ticks synchronous to i_mclk
// Notes: sysclk and clock out are levels rebuilt from ticks
//
// How it works
// - after reset the system clock runs from the internal oscillator
// - internal divide code 00 /8, 01 /4, 10 /2, 11 /1
// - internal control bit 7 enables the internal oscillator, reset enabled
// - ready flag bit 6 reads one only while oscillator runs at programmed rate
// - eight-bit trim sets oscillator period, factory preset, software writable
// - source code 00 internal, 01 external, 10 pll, 11 reserved
// - clock out divide code 00 /1, 01 /2, 10 /4, 11 /8
// - source may change at run time; software picks only settled sources
// - enable internal oscillator, then select it in the next write, no wait for ready
// - external oscillator stays available to timers whatever the source
// - crystal valid flag bit 7 set once settled, only in crystal modes
// - pll lock flag set only when the pll is locked
// - external mode: 00x off, 01x cmos, 10x rc, 11x crystal; halved in rc or when bit 0 is set
// - three-bit external range code sets oscillator drive range
// - external control bit 3 reads zero, writes ignored
`timescale 1ns/1ps
module ssc_clock_select #(
  parameter logic [3:0] READY_TICKS = ssc_pkg::INT_READY_TICKS
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [7:0] i_factory_trim,
  input wire logic i_int_osc_tick,
  input wire logic i_ext_osc_tick,
  input wire logic i_pll_tick,
  input wire logic i_xtal_amp_ok,
  input wire logic i_pll_locked,
  output logic o_int_osc_on,
  output logic [7:0] o_int_osc_trim,
  output logic [2:0] o_ext_osc_mode,
  output logic [2:0] o_ext_osc_range,
  output logic o_ext_osc_tick,
  output logic o_sysclk,
  output logic o_sysclk_tick,
  output logic [1:0] o_sysclk_source,
  output logic o_clock_out,
  output logic o_int_osc_ready_flag,
  output logic o_crystal_valid_flag,
  output logic o_pll_lock_flag
);

  // ==========================================================
  // register state
  logic [7:0] trim_q;
  logic trim_loaded_q;
  logic int_on_q;
  logic [1:0] int_div_q;
  logic [2:0] ext_mode_q;
  logic [2:0] ext_range_q;
  logic [1:0] clkout_div_q;
  logic [1:0] src_code_q;
  logic [3:0] ready_cnt_q;
  logic ready_q;
  logic pll_lock_q;
  logic [7:0] rdata_q;

  // ==========================================================
  // clock path state
  logic [1:0] active_src_q;
  logic sysclk_q;
  logic sysclk_tick_q;
  logic clock_out_q;
  logic ext_tick_q;
  logic src_tick;
  logic switch_now;
  logic toggle_now;

  // ==========================================================
  // write decode
  logic wr_trim;
  logic wr_int;
  logic wr_ext;
  logic wr_sel;

  assign wr_trim = i_sfr_wr && (i_sfr_addr == ssc_pkg::ADDR_INT_TRIM);
  assign wr_int = i_sfr_wr && (i_sfr_addr == ssc_pkg::ADDR_INT_CTRL);
  assign wr_ext = i_sfr_wr && (i_sfr_addr == ssc_pkg::ADDR_EXT_CTRL);
  assign wr_sel = i_sfr_wr && (i_sfr_addr == ssc_pkg::ADDR_SRC_SEL);

  // ==========================================================
  // sub-blocks
  ssc_tick_if int_if ();
  ssc_tick_if ext_if ();
  ssc_tick_if out_if ();

  // internal divider: shift is 3 - code
  assign int_if.tick_in = i_int_osc_tick && int_on_q;
  assign int_if.shift = ~int_div_q;
  assign int_if.mode = 3'h0;
  assign int_if.stat_in = 1'b0;

  assign ext_if.tick_in = i_ext_osc_tick;
  assign ext_if.shift = 2'h0;
  assign ext_if.mode = ext_mode_q;
  assign ext_if.stat_in = i_xtal_amp_ok;

  // clock out divider counts sysclk half periods
  assign out_if.tick_in = toggle_now;
  assign out_if.shift = clkout_div_q;
  assign out_if.mode = 3'h0;
  assign out_if.stat_in = 1'b0;

  ssc_tick_div u_int_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .bus(int_if)
  );

  ssc_ext_osc u_ext_osc (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .bus(ext_if)
  );

  ssc_tick_div u_out_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .bus(out_if)
  );

  // ==========================================================
  // trim register, factory value caught after reset release
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      trim_q <= ssc_pkg::TRIM_PRELOAD;
      trim_loaded_q <= 1'b0;
    end else if (!trim_loaded_q) begin
      trim_q <= i_factory_trim;
      trim_loaded_q <= 1'b1;
    end else if (wr_trim) begin
      trim_q <= i_sfr_wdata;
    end
  end

  // ==========================================================
  // internal oscillator control
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      int_on_q <= ssc_pkg::INT_CTRL_RESET[ssc_pkg::INT_ON_BIT];
      int_div_q <= ssc_pkg::INT_CTRL_RESET[ssc_pkg::INT_DIV_LSB +: 2];
    end else if (wr_int) begin
      int_on_q <= i_sfr_wdata[ssc_pkg::INT_ON_BIT];
      int_div_q <= i_sfr_wdata[ssc_pkg::INT_DIV_LSB +: 2];
    end
  end

  // ready after a run of oscillator ticks; restarts on any retune
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ready_cnt_q <= 4'h0;
      ready_q <= 1'b0;
    end else if (!int_on_q || wr_trim || wr_int) begin
      ready_cnt_q <= 4'h0;
      ready_q <= 1'b0;
    end else begin
      if (i_int_osc_tick && (ready_cnt_q != READY_TICKS)) begin
        ready_cnt_q <= ready_cnt_q + 4'h1;
      end
      ready_q <= (ready_cnt_q == READY_TICKS);
    end
  end

  // ==========================================================
  // external oscillator control and select register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ext_mode_q <= ssc_pkg::EXT_CTRL_RESET[ssc_pkg::EXT_MODE_LSB +: 3];
      ext_range_q <= ssc_pkg::EXT_CTRL_RESET[ssc_pkg::EXT_RANGE_LSB +: 3];
    end else if (wr_ext) begin
      ext_mode_q <= i_sfr_wdata[ssc_pkg::EXT_MODE_LSB +: 3];
      ext_range_q <= i_sfr_wdata[ssc_pkg::EXT_RANGE_LSB +: 3];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      clkout_div_q <= ssc_pkg::SRC_SEL_RESET[ssc_pkg::CLKOUT_DIV_LSB +: 2];
      src_code_q <= ssc_pkg::SRC_SEL_RESET[ssc_pkg::SRC_LSB +: 2];
    end else if (wr_sel) begin
      clkout_div_q <= i_sfr_wdata[ssc_pkg::CLKOUT_DIV_LSB +: 2];
      src_code_q <= i_sfr_wdata[ssc_pkg::SRC_LSB +: 2];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pll_lock_q <= 1'b0;
    end else begin
      pll_lock_q <= i_pll_locked;
    end
  end

  // ==========================================================
  // source mux and glitch-free switch
  always_comb begin
    case (active_src_q)
      ssc_pkg::SRC_INT: src_tick = int_if.tick_out;
      ssc_pkg::SRC_EXT: src_tick = ext_if.tick_out;
      ssc_pkg::SRC_PLL: src_tick = i_pll_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // change only while sysclk is low, reserved code keeps old source
  assign switch_now = !sysclk_q && (src_code_q != ssc_pkg::SRC_RESERVED)
                      && (src_code_q != active_src_q);
  assign toggle_now = src_tick && !switch_now;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      active_src_q <= ssc_pkg::SRC_INT;
    end else if (switch_now) begin
      active_src_q <= src_code_q;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sysclk_q <= 1'b0;
      sysclk_tick_q <= 1'b0;
    end else begin
      sysclk_tick_q <= toggle_now && !sysclk_q;
      if (toggle_now) begin
        sysclk_q <= ~sysclk_q;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      clock_out_q <= 1'b0;
    end else if (out_if.tick_out) begin
      clock_out_q <= ~clock_out_q;
    end
  end

  // external tick to timers regardless of the selected source
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ext_tick_q <= 1'b0;
    end else begin
      ext_tick_q <= ext_if.tick_out;
    end
  end

  // ==========================================================
  // register read, unmapped reads zero
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        ssc_pkg::ADDR_INT_TRIM: rdata_q <= trim_q;
        ssc_pkg::ADDR_INT_CTRL: rdata_q <= {int_on_q, ready_q, 4'h0, int_div_q};
        ssc_pkg::ADDR_EXT_CTRL: rdata_q <= {ext_if.stat_out, ext_mode_q, 1'b0, ext_range_q};
        ssc_pkg::ADDR_SRC_SEL: rdata_q <= {2'h0, clkout_div_q, 2'h0, src_code_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign o_sfr_rdata = rdata_q;
  assign o_int_osc_on = int_on_q;
  assign o_int_osc_trim = trim_q;
  assign o_ext_osc_mode = ext_mode_q;
  assign o_ext_osc_range = ext_range_q;
  assign o_ext_osc_tick = ext_tick_q;
  assign o_sysclk = sysclk_q;
  assign o_sysclk_tick = sysclk_tick_q;
  assign o_sysclk_source = active_src_q;
  assign o_clock_out = clock_out_q;
  assign o_int_osc_ready_flag = ready_q;
  assign o_crystal_valid_flag = ext_if.stat_out;
  assign o_pll_lock_flag = pll_lock_q;

endmodule

// file: rtl/ssc_ext_osc.sv
// Purpose: condition the external oscillator tick by mode
// Assumes: tick_in and stat_in synchronous to i_mclk
// Notes: stat_in is the amplitude detector, stat_out the crystal valid flag
`timescale 1ns/1ps
module ssc_ext_osc (
  input wire logic i_mclk,
  input wire logic i_reset,
  ssc_tick_if.ext bus
);

  logic off;
  logic halved;
  logic phase_q;
  logic tick_q;
  logic valid_q;

  // 00x off, 01x cmos, 10x rc, 11x crystal; halved in rc or when bit 0 is set
  assign off = (bus.mode[2:1] == ssc_pkg::EXT_OFF);
  assign halved = (bus.mode[2:1] == ssc_pkg::EXT_RC) || bus.mode[0];
  assign bus.tick_out = tick_q;
  assign bus.stat_out = valid_q;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      phase_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (off) begin
      phase_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= bus.tick_in && (!halved || phase_q);
      if (bus.tick_in) begin
        phase_q <= ~phase_q;
      end
    end
  end

  // only meaningful in crystal modes, zero otherwise
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= (bus.mode[2:1] == ssc_pkg::EXT_CRYSTAL) && bus.stat_in;
    end
  end

endmodule

// file: rtl/ssc_tick_div.sv
// Purpose: divide a tick stream by 1, 2, 4 or 8
// Assumes: tick_in is a one-cycle pulse
// Notes: tick_out is registered, one cycle after the last input tick
`timescale 1ns/1ps
module ssc_tick_div (
  input wire logic i_mclk,
  input wire logic i_reset,
  ssc_tick_if.div bus
);

  logic [2:0] cnt_q;
  logic [2:0] lim;
  logic tick_q;

  assign lim = 3'((4'h1 << bus.shift) - 4'h1);
  assign bus.tick_out = tick_q;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (bus.tick_in) begin
        if (cnt_q >= lim) begin
          cnt_q <= 3'h0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end

endmodule
